// ===== core/byte_reg.sv
// single byte holding register with load enable, read data registered
// assumes synchronous active high reset
module byte_reg (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // load side
   input wire logic load,
   input wire logic [7:0] din,
   // held value
   output logic [7:0] dout
);
   always_ff @(posedge clk) begin
      if (rst) begin
         dout <= 8'h00;
      end else if (load) begin
         dout <= din;
      end
   end
endmodule

// ===== core/host_parallel_slave_port.sv
// host parallel slave port: host strobes on pins, firmware registers on a byte port
// assumes host pins are asynchronous; firmware port runs on clk
module host_parallel_slave_port
   import hport_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host pins
   input wire logic cs_n,
   input wire logic port_select,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic host_data_oe,
   output logic aux_pin,
   // firmware register port
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // interrupt
   output logic irq
);
   typedef struct packed {
      host_state_e hst;
      logic [2:0] xfer_st;
      logic aux;
      logic irq_en;
      logic irq_st;
      logic [7:0] rdata;
      logic [7:0] hout;
      logic hoe;
      logic irq_o;
   } state_s;

   state_s q, d;
   host_pins_s pins_raw, pins;
   reg_req_s req;
   logic [7:0] rx_buf, tx_buf;
   logic rx_load, tx_load;
   logic [7:0] rx_din;
   logic rd_start, wr_start;
   logic host_evt;

   function automatic logic busy_of(input logic [2:0] st);
      busy_of = |st;
   endfunction

   assign pins_raw = '{cs_n: cs_n, port_select: port_select, rd_n: rd_n, wr_n: wr_n,
                       data: host_data_in};
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   pin_sync u_sync (
      .clk(clk),
      .rst(rst),
      .pins_in(pins_raw),
      .pins_out(pins)
   );

   // rx buffer loads on the host write edge, tx buffer on firmware write
   byte_reg u_rx (
      .clk(clk),
      .rst(rst),
      .load(rx_load),
      .din(rx_din),
      .dout(rx_buf)
   );
   byte_reg u_tx (
      .clk(clk),
      .rst(rst),
      .load(tx_load),
      .din(req.wdata),
      .dout(tx_buf)
   );

   // decode of the three control pins cs_n, rd_n and wr_n
   assign rd_start = !pins.cs_n && !pins.rd_n && pins.wr_n;
   assign wr_start = !pins.cs_n && !pins.wr_n && pins.rd_n;
   assign rx_din = pins.data;
   assign rx_load = (q.hst == hs_idle) && wr_start;
   assign tx_load = req.wr && (req.addr == host_port_data_buffer_off);

   always_comb begin
      d = q;
      d.rdata = 8'h00;
      host_evt = 1'b0;
      // host side sequencing: act once per strobe
      case (q.hst)
         hs_idle: begin
            if (wr_start) begin
               d.hst = hs_wr;
               d.xfer_st = pins.port_select ? st_cmd_wr : st_dat_wr;
               host_evt = 1'b1;
            end else if (rd_start) begin
               d.hst = hs_rd;
               d.hoe = 1'b1;
               if (pins.port_select) begin
                  d.hout = {7'h00, busy_of(q.xfer_st)};
               end else begin
                  d.hout = tx_buf;
               end
            end
         end
         hs_rd: begin
            if (pins.cs_n || pins.rd_n) begin
               d.hst = hs_idle;
               d.hoe = 1'b0;
               if (!pins.port_select) begin
                  d.xfer_st = st_dat_rd;
                  host_evt = 1'b1;
               end
            end
         end
         hs_wr: begin
            if (pins.cs_n || pins.wr_n) begin
               d.hst = hs_idle;
            end
         end
         default: d.hst = hs_idle;
      endcase
      // any change of transfer status to a value other than st_reset sets the sticky interrupt bit
      if (d.xfer_st != q.xfer_st && d.xfer_st != st_reset) begin
         d.irq_st = 1'b1;
      end
      // firmware writes
      if (req.wr) begin
         if (req.addr == host_port_status_off) begin
            d.aux = req.wdata[aux_bit];
         end else if (req.addr == irq_enable_reg_off) begin
            d.irq_en = req.wdata[irq_bit];
         end else if (req.addr == irq_status_reg_off) begin
            if (!req.wdata[irq_bit]) begin
               // a fresh host event in this cycle still wins
               if (!host_evt) begin
                  d.xfer_st = st_reset;
                  d.irq_st = 1'b0;
               end
            end
         end
      end
      // firmware reads, data one cycle later
      if (req.rd) begin
         if (req.addr == host_port_status_off) begin
            d.rdata = {5'h00, q.xfer_st};
         end else if (req.addr == host_port_data_buffer_off) begin
            d.rdata = rx_buf;
         end else if (req.addr == irq_enable_reg_off) begin
            d.rdata = {4'h0, q.irq_en, 3'h0};
         end else if (req.addr == irq_status_reg_off) begin
            d.rdata = {4'h0, q.irq_st, 3'h0};
         end else begin
            d.rdata = 8'h00;
         end
      end
      d.irq_o = d.irq_st && d.irq_en;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q.hst <= hs_idle;
         q.xfer_st <= st_reset;
         q.aux <= aux_reset;
         q.irq_en <= 1'b0;
         q.irq_st <= 1'b0;
         q.rdata <= buf_reset;
         q.hout <= buf_reset;
         q.hoe <= 1'b0;
         q.irq_o <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign host_data_out = q.hout;
   assign host_data_oe = q.hoe;
   assign aux_pin = q.aux;
   assign reg_rdata = q.rdata;
   assign irq = q.irq_o;

   sequence host_write_s;
      q.hst == hs_idle && wr_start;
   endsequence

   onehot_status_a: assert property (@(posedge clk) disable iff (rst)
      $onehot0(q.xfer_st)) else $error("transfer status not exclusive");
   cmd_write_a: assert property (@(posedge clk) disable iff (rst)
      host_write_s and pins.port_select |=> q.xfer_st == st_cmd_wr)
      else $error("command write status wrong");
   data_write_a: assert property (@(posedge clk) disable iff (rst)
      host_write_s and !pins.port_select |=> q.xfer_st == st_dat_wr && rx_buf == $past(pins.data))
      else $error("data write status wrong");
   tx_read_a: assert property (@(posedge clk) disable iff (rst)
      q.hst == hs_rd && pins.rd_n && !pins.port_select |=> q.xfer_st == st_dat_rd)
      else $error("tx read status wrong");
   busy_read_a: assert property (@(posedge clk) disable iff (rst)
      q.hst == hs_idle && rd_start && pins.port_select && !wr_start
      |=> q.hout == {7'h00, |$past(q.xfer_st)} && q.hoe)
      else $error("busy read wrong");
   aux_write_a: assert property (@(posedge clk) disable iff (rst)
      req.wr && req.addr == host_port_status_off |=> aux_pin == $past(reg_wdata[1]))
      else $error("aux pin not following write");
   irq_level_a: assert property (@(posedge clk) disable iff (rst)
      $changed(q.xfer_st) && q.xfer_st != st_reset && q.irq_en |-> irq)
      else $error("irq not raised on status change");
   rx_read_a: assert property (@(posedge clk) disable iff (rst)
      req.rd && req.addr == host_port_data_buffer_off |=> reg_rdata == $past(rx_buf))
      else $error("data read wrong");
   deselect_a: assert property (@(posedge clk) disable iff (rst)
      pins.cs_n && q.hst == hs_idle |=> $stable(q.xfer_st) || q.xfer_st == st_reset)
      else $error("activity while deselected");

   // host read path, then write strobe hold and receive buffer hold
   sequence host_read_s;
      q.hst == hs_idle && rd_start;
   endsequence
   sequence host_read_end_s;
      q.hst == hs_rd && (pins.cs_n || pins.rd_n);
   endsequence
   read_oe_a: assert property (@(posedge clk) disable iff (rst)
      host_read_s |=> host_data_oe && q.hst == hs_rd) else $error("read strobe not answered");
   tx_out_a: assert property (@(posedge clk) disable iff (rst)
      host_read_s and !pins.port_select |=> host_data_out == $past(tx_buf))
      else $error("data port read not from transmit buffer");
   read_hold_a: assert property (@(posedge clk) disable iff (rst)
      q.hst == hs_rd && !pins.cs_n && !pins.rd_n |=> host_data_oe && $stable(host_data_out))
      else $error("read data not held");
   read_end_a: assert property (@(posedge clk) disable iff (rst)
      host_read_end_s |=> !host_data_oe && q.hst == hs_idle) else $error("bus not released");
   cmd_read_keep_a: assert property (@(posedge clk) disable iff (rst)
      host_read_end_s and pins.port_select
      |=> q.xfer_st == $past(q.xfer_st) || q.xfer_st == st_reset)
      else $error("command read changed status");
   deselect_oe_a: assert property (@(posedge clk) disable iff (rst)
      pins.cs_n |=> !host_data_oe) else $error("bus driven while deselected");
   both_strobes_a: assert property (@(posedge clk) disable iff (rst)
      q.hst == hs_idle && !pins.cs_n && !pins.rd_n && !pins.wr_n
      |=> q.hst == hs_idle && !host_data_oe) else $error("both strobes acted on");
   write_once_a: assert property (@(posedge clk) disable iff (rst)
      q.hst == hs_wr && !pins.cs_n && !pins.wr_n |=> q.hst == hs_wr && $stable(rx_buf))
      else $error("one write strobe taken twice");
   rx_hold_a: assert property (@(posedge clk) disable iff (rst)
      !rx_load |=> $stable(rx_buf)) else $error("receive buffer changed");

   // firmware register path, then reset values
   sequence irq_clear_s;
      req.wr && req.addr == irq_status_reg_off && !req.wdata[irq_bit];
   endsequence
   sequence irq_keep_s;
      req.wr && req.addr == irq_status_reg_off && req.wdata[irq_bit];
   endsequence
   clear_all_a: assert property (@(posedge clk) disable iff (rst)
      irq_clear_s and !host_evt |=> q.xfer_st == st_reset && !q.irq_st && !irq)
      else $error("status clear incomplete");
   clear_loses_a: assert property (@(posedge clk) disable iff (rst)
      irq_clear_s and host_evt |=> q.xfer_st != st_reset) else $error("clear beat host event");
   write_one_a: assert property (@(posedge clk) disable iff (rst)
      irq_keep_s and !host_evt |=> $stable(q.xfer_st) && $stable(q.irq_st))
      else $error("writing one changed status");
   aux_only_a: assert property (@(posedge clk) disable iff (rst)
      req.wr && req.addr == host_port_status_off && !host_evt |=> $stable(q.xfer_st))
      else $error("status write changed transfer bits");
   status_read_a: assert property (@(posedge clk) disable iff (rst)
      req.rd && req.addr == host_port_status_off |=> reg_rdata == {5'h00, $past(q.xfer_st)})
      else $error("status read wrong");
   irq_en_write_a: assert property (@(posedge clk) disable iff (rst)
      req.wr && req.addr == irq_enable_reg_off |=> q.irq_en == $past(req.wdata[irq_bit]))
      else $error("irq enable not written");
   irq_en_read_a: assert property (@(posedge clk) disable iff (rst)
      req.rd && req.addr == irq_enable_reg_off |=> reg_rdata == {4'h0, $past(q.irq_en), 3'h0})
      else $error("irq enable read wrong");
   irq_st_read_a: assert property (@(posedge clk) disable iff (rst)
      req.rd && req.addr == irq_status_reg_off |=> reg_rdata == {4'h0, $past(q.irq_st), 3'h0})
      else $error("irq status read wrong");
   rdata_idle_a: assert property (@(posedge clk) disable iff (rst)
      !req.rd |=> reg_rdata == 8'h00) else $error("read data outside read cycle");
   tx_load_a: assert property (@(posedge clk) disable iff (rst)
      tx_load |=> tx_buf == $past(req.wdata)) else $error("transmit buffer not loaded");
   tx_hold_a: assert property (@(posedge clk) disable iff (rst)
      !tx_load |=> $stable(tx_buf)) else $error("transmit buffer changed");
   reset_values_a: assert property (@(posedge clk)
      rst |=> q.xfer_st == st_reset && aux_pin == aux_reset && rx_buf == buf_reset
      && tx_buf == buf_reset && !host_data_oe && !irq) else $error("reset values wrong");
endmodule

// ===== core/hport_pkg.sv
// package for the host parallel slave port: register map, field layout, reset values
// assumes a single clock domain and a byte-wide firmware register port
package hport_pkg;
   localparam logic [15:0] host_port_status_off = 16'h101a;
   localparam logic [15:0] host_port_data_buffer_off = 16'h101b;
   // interrupt registers: offsets chosen for this block
   localparam logic [15:0] irq_enable_reg_off = 16'h1001;
   localparam logic [15:0] irq_status_reg_off = 16'h1002;
   localparam int irq_bit = 3;
   localparam int aux_bit = 1;
   localparam logic [2:0] st_cmd_wr = 3'h1;
   localparam logic [2:0] st_dat_wr = 3'h2;
   localparam logic [2:0] st_dat_rd = 3'h4;
   localparam logic [2:0] st_reset = 3'h0;
   localparam logic [7:0] buf_reset = 8'h00;
   localparam logic aux_reset = 1'b0;

   typedef struct packed {
      logic cs_n;
      logic port_select;
      logic rd_n;
      logic wr_n;
      logic [7:0] data;
   } host_pins_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

   typedef enum logic [2:0] {
      hs_idle = 3'b001,
      hs_rd = 3'b010,
      hs_wr = 3'b100
   } host_state_e;
endpackage

// ===== core/pin_sync.sv
// two-flop synchroniser for the host strobes and bus
// assumes inputs are asynchronous to clk
module pin_sync
   import hport_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // raw and synchronised pins
   input wire host_pins_s pins_in,
   output host_pins_s pins_out
);
   typedef struct packed {
      host_pins_s s1;
      host_pins_s s2;
   } sync_s;
   sync_s q, d;
   localparam host_pins_s idle_pins = '{cs_n: 1'b1, port_select: 1'b0, rd_n: 1'b1,
                                       wr_n: 1'b1, data: 8'h00};
   always_comb begin
      d.s1 = pins_in;
      d.s2 = q.s1;
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         q.s1 <= idle_pins;
         q.s2 <= idle_pins;
      end else begin
         q <= d;
      end
   end
   assign pins_out = q.s2;
endmodule

// ===== verif/host_model.sv
// host controller model: drives select, port select, strobes and write data
// assumes the port drives the bus within 24 clocks of a read strobe
module host_model
   import hport_pkg::*;
(
   // clock
   input wire logic clk,
   // pins toward the port
   output logic cs_n,
   output logic port_select,
   output logic rd_n,
   output logic wr_n,
   output logic [7:0] host_data_in,
   input wire logic [7:0] host_data_out,
   input wire logic host_data_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n = 1'b1;
      port_select = 1'b0;
      rd_n = 1'b1;
      wr_n = 1'b1;
      host_data_in = 8'h00;
   end
   // write strobe held past the sync delay, then a long gap
   task automatic host_write(input logic sel_n, input logic ps, input logic [7:0] d);
      @(posedge clk);
      cs_n <= sel_n;
      port_select <= ps;
      wr_n <= 1'b0;
      host_data_in <= d;
      repeat (5) @(posedge clk);
      cs_n <= 1'b1;
      wr_n <= 1'b1;
      host_data_in <= ~d;
      repeat (6) @(posedge clk);
   endtask
   // read strobe held until the bus is driven; busy polled this way
   task automatic host_read(input logic ps, output logic [7:0] d, output logic seen);
      @(posedge clk);
      cs_n <= 1'b0;
      port_select <= ps;
      rd_n <= 1'b0;
      repeat (4) @(posedge clk);
      seen = 1'b0;
      d = 8'h00;
      for (int i = 0; i < 20 && !seen; i++) begin
         @(posedge clk);
         seen = (host_data_oe === 1'b1);
         d = host_data_out;
      end
      cs_n <= 1'b1;
      rd_n <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
endmodule

// ===== verif/host_parallel_slave_port_test.sv
// self-checking bench for the host parallel slave port
// assumes host_model on the pins and firmware tasks on the register port
module host_parallel_slave_port_test;
   import hport_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n, port_select, rd_n, wr_n, host_data_oe, aux_pin, irq, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] host_data_in, host_data_out, reg_wdata = 8'h00, reg_rdata, d;
   logic [15:0] reg_addr = 16'h0000;
   logic seen;
   int n_fail = 0;
   int checked = 0;
   always #2 clk = ~clk;
   host_model u_host_model (.clk(clk), .cs_n(cs_n), .port_select(port_select), .rd_n(rd_n),
      .wr_n(wr_n), .host_data_in(host_data_in), .host_data_out(host_data_out),
      .host_data_oe(host_data_oe));
   host_parallel_slave_port u_host_parallel_slave_port (.clk(clk), .rst(rst), .cs_n(cs_n),
      .port_select(port_select), .rd_n(rd_n), .wr_n(wr_n), .host_data_in(host_data_in),
      .host_data_out(host_data_out), .host_data_oe(host_data_oe), .aux_pin(aux_pin),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         n_fail++;
      end
   endtask
   task automatic reg_write(input logic [15:0] a, input logic [7:0] v);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rchk(input string what, input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(what, exp, reg_rdata);
   endtask
   task automatic t_reset();
      rchk("status", host_port_status_off, 8'h00);
      rchk("data", host_port_data_buffer_off, buf_reset);
      u_host_model.host_read(1'b0, d, seen);
      chk("tx", buf_reset, d);
      reg_write(irq_status_reg_off, 8'h00);
      rchk("irq status", irq_status_reg_off, 8'h00);
      chk("aux", 8'h00, {7'h0, aux_pin});
      $display("test reset done");
   endtask
   task automatic t_cmd_write();
      reg_write(irq_enable_reg_off, 8'h08);
      u_host_model.host_write(1'b0, 1'b1, 8'h5a);
      rchk("status", host_port_status_off, {5'h0, st_cmd_wr});
      rchk("rx", host_port_data_buffer_off, 8'h5a);
      rchk("irq status", irq_status_reg_off, 8'h08);
      chk("irq", 8'h01, {7'h0, irq});
      u_host_model.host_read(1'b1, d, seen);
      chk("busy", 8'h01, d);
      reg_write(irq_status_reg_off, 8'hff);
      rchk("status", host_port_status_off, {5'h0, st_cmd_wr});
      reg_write(irq_status_reg_off, 8'hf7);
      rchk("status", host_port_status_off, {5'h0, st_reset});
      chk("irq", 8'h00, {7'h0, irq});
      u_host_model.host_read(1'b1, d, seen);
      chk("busy", 8'h00, d);
      $display("test command write done");
   endtask
   task automatic t_data_write();
      u_host_model.host_write(1'b0, 1'b0, 8'hc3);
      rchk("status", host_port_status_off, {5'h0, st_dat_wr});
      rchk("rx", host_port_data_buffer_off, 8'hc3);
      reg_write(irq_status_reg_off, 8'h00);
      $display("test data write done");
   endtask
   task automatic t_data_read();
      reg_write(irq_enable_reg_off, 8'h00);
      reg_write(host_port_data_buffer_off, 8'h96);
      u_host_model.host_read(1'b0, d, seen);
      chk("oe", 8'h01, {7'h0, seen});
      chk("tx", 8'h96, d);
      rchk("status", host_port_status_off, {5'h0, st_dat_rd});
      rchk("irq status", irq_status_reg_off, 8'h08);
      chk("masked irq", 8'h00, {7'h0, irq});
      reg_write(irq_status_reg_off, 8'h00);
      $display("test data read done");
   endtask
   task automatic t_aux_deselect();
      reg_write(host_port_status_off, 8'h02);
      chk("aux", 8'h01, {7'h0, aux_pin});
      rchk("status", host_port_status_off, 8'h00);
      reg_write(host_port_status_off, 8'hfd);
      chk("aux", 8'h00, {7'h0, aux_pin});
      u_host_model.host_write(1'b1, 1'b0, 8'h11);
      rchk("status", host_port_status_off, 8'h00);
      rchk("rx", host_port_data_buffer_off, 8'hc3);
      rchk("unmapped", 16'h1003, 8'h00);
      $display("test aux and deselect done");
   endtask
   task automatic print_verdict();
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_cmd_write();
      t_data_write();
      t_data_read();
      t_aux_deselect();
      print_verdict();
   end
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      print_verdict();
   end
endmodule
